// ---- inc/sct_defines.svh ----
// register offsets, bit positions, reset values and counts for the core
`ifndef SCT_DEFINES_SVH
`define SCT_DEFINES_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define SCT_A_STS 8'h00
`define SCT_A_RXD 8'h04
`define SCT_A_TXD 8'h08
`define SCT_A_CRA 8'h0c
`define SCT_A_CRB 8'h10
`define SCT_A_CRC 8'h14
`define SCT_A_BRR 8'h18
`define SCT_A_REQ 8'h1c
// ---------------------------------------------------------------
// status bit positions
// ---------------------------------------------------------------
`define SCT_S_TXC 1
`define SCT_S_RXNE 2
`define SCT_S_IDLE 6
// ---------------------------------------------------------------
// reset values and counts
// ---------------------------------------------------------------
`define SCT_BRR_RST 16'h0001
`define SCT_ONES12 12'hfff
`define SCT_OS16_LAST 4'hf
`define SCT_OS8_LAST 4'h7
`define SCT_MID16 4'h8
`define SCT_MID8 4'h4
`define SCT_STOP2 2'h2
`endif

// ---- inc/sct_pkg.sv ----
// types shared by the serial character core
package sct_pkg;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } sct_rx_state_t;
   typedef struct packed {
      logic idle_int_en;
      logic rx_not_empty_int_en;
      logic tx_complete_int_en;
      logic tx_empty_int_en;
      logic parity_odd;
      logic parity_enable;
      logic [1:0] word_length_sel;
      logic oversample_sel;
      logic receiver_enable;
      logic transmitter_enable;
      logic module_enable;
   } sct_ctrl_a_t;
endpackage

// ---- core/sct_core.sv ----
// serial character transmit and receive core with apb register slave
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "sct_defines.svh"
//
// Functional notes
// - idle frame precedes first data frame
// - lsb first, start low, stop high
// - move to shifter sets buffer empty
// - transmit data write clears buffer empty
// - busy transmitter keeps word in holding
// - idle transmitter loads word at once
// - frame end with empty buffer sets complete
// - break after current frame, then cleared
// - break request cleared early sends nothing
// - receiver assembles lsb first in shifter
// - transfer to data register sets not-empty
// - not-empty clear by read, or zero write in single-buffer mode
// - received break counts as frame error
// - received idle frame flags idle interrupt
// - sampling at 8x or 16x baud
// - overrun keeps old data, drops new
// - overrun clears on status then data read
// - noise flag set with not-empty
// - missing stop bit sets frame error
// - word length 8, 9 or 7 bits
module sct_core #(
   parameter int BAUD_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rxd,
   output logic txd,
   output logic irq,
   output logic tx_dma_req,
   output logic rx_dma_req
);
   import sct_pkg::*;

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // word length decode
   function automatic logic [3:0] wl_bits(input logic [1:0] s);
      case (s)
         2'h1: wl_bits = 4'h9;
         2'h2: wl_bits = 4'h7;
         default: wl_bits = 4'h8;
      endcase
   endfunction

   // start low, data lsb first, stop ones
   function automatic logic [11:0] frame(input logic [8:0] d,
                                         input logic [3:0] nb);
      logic [11:0] v;
      v = 12'hffe;
      for (int i = 0; i < 9; i++) begin
         if (4'(i) < nb) begin
            v[i+1] = d[i];
         end
      end
      return v;
   endfunction

   // parity replaces the top data bit
   function automatic logic [8:0] add_par(input logic [8:0] d,
                                          input logic [3:0] nb,
                                          input logic odd);
      logic [8:0] v;
      logic p;
      v = d;
      p = odd;
      for (int i = 0; i < 8; i++) begin
         if (4'(i) < 4'(nb - 4'h1)) begin
            p = p ^ d[i];
         end
      end
      v[4'(nb - 4'h1)] = p;
      return v;
   endfunction

   function automatic logic maj3(input logic [2:0] s);
      return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   sct_ctrl_a_t cra;
   logic [1:0] stop_bits_sel;
   logic error_int_en, dma_rx_en, dma_tx_en;
   logic [BAUD_W-1:0] baud_div, div_cnt;
   logic break_send_request;
   logic [8:0] tx_hold, rx_data, rx_sh, rx_algn, txw;
   logic tx_buffer_empty_flag, tx_complete_flag, rx_not_empty_flag;
   logic overrun_flag, noise_flag, framing_err_flag, idle_flag;
   logic sts_seen, acc, hit, os_tick;
   logic wr_sts, wr_txd, wr_cra, wr_crb, wr_crc, wr_brr, wr_req;
   logic rd_sts, rd_rxd;
   logic [31:0] rd_val;
   logic [3:0] os_last, os_mid, nbits, flen;
   logic te_q, idle_pend, tx_brk, tx_run, tx_busy, bit_end, tx_done;
   logic ld_idle, ld_brk, ld_data;
   logic [3:0] tx_os, tx_left, rx_os, rx_idx, idle_bits;
   logic [11:0] tx_shift;
   sct_rx_state_t rx_st;
   logic [2:0] smp;
   logic rx_run, rx_mid, bitv, bit_nz, nf_acc, idle_arm;
   logic rx_done, rx_clr, rxne_eff, idle_hit;

   // ------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------
   // zero wait states; unmapped offsets answer with pslverr
   assign acc = psel & penable;
   assign pready = 1'h1;
   assign hit = (paddr[1:0] == 2'h0) && (paddr <= `SCT_A_REQ);
   assign pslverr = acc & !hit;
   assign wr_sts = acc & pwrite & (paddr == `SCT_A_STS);
   assign wr_txd = acc & pwrite & (paddr == `SCT_A_TXD);
   assign wr_cra = acc & pwrite & (paddr == `SCT_A_CRA);
   assign wr_crb = acc & pwrite & (paddr == `SCT_A_CRB);
   assign wr_crc = acc & pwrite & (paddr == `SCT_A_CRC);
   assign wr_brr = acc & pwrite & (paddr == `SCT_A_BRR);
   assign wr_req = acc & pwrite & (paddr == `SCT_A_REQ);
   assign rd_sts = acc & !pwrite & (paddr == `SCT_A_STS);
   assign rd_rxd = acc & !pwrite & (paddr == `SCT_A_RXD);

   always_comb begin
      rd_val = 32'h0;
      case (paddr)
         `SCT_A_STS: rd_val = {25'h0, idle_flag, framing_err_flag,
                               noise_flag, overrun_flag,
                               rx_not_empty_flag, tx_complete_flag,
                               tx_buffer_empty_flag};
         `SCT_A_RXD: rd_val = {23'h0, rx_data};
         `SCT_A_CRA: rd_val = {20'h0, cra};
         `SCT_A_CRB: rd_val = {30'h0, stop_bits_sel};
         `SCT_A_CRC: rd_val = {29'h0, dma_tx_en, dma_rx_en, error_int_en};
         `SCT_A_BRR: rd_val = 32'(baud_div);
         `SCT_A_REQ: rd_val = {31'h0, break_send_request};
         default: rd_val = 32'h0;
      endcase
   end

   // read data is captured in the setup phase so it comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_val;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cra <= '0;
         stop_bits_sel <= 2'h0;
         error_int_en <= 1'h0;
         dma_rx_en <= 1'h0;
         dma_tx_en <= 1'h0;
         baud_div <= BAUD_W'(`SCT_BRR_RST);
      end else begin
         if (wr_cra) begin
            cra <= sct_ctrl_a_t'(pwdata[11:0]);
         end
         if (wr_crb) begin
            stop_bits_sel <= pwdata[1:0];
         end
         if (wr_crc) begin
            {dma_tx_en, dma_rx_en, error_int_en} <= pwdata[2:0];
         end
         if (wr_brr) begin
            baud_div <= pwdata[BAUD_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // oversampling tick
   // ------------------------------------------------------------
   // bit period is 16 or 8 ticks
   assign os_last = cra.oversample_sel ? `SCT_OS8_LAST : `SCT_OS16_LAST;
   assign os_mid = cra.oversample_sel ? `SCT_MID8 : `SCT_MID16;
   // a divider of zero behaves as one
   assign os_tick = BAUD_W'(div_cnt + 1'h1) >= baud_div;
   assign nbits = wl_bits(cra.word_length_sel);
   assign flen = 4'(nbits + ((stop_bits_sel == `SCT_STOP2) ? 4'h3 : 4'h2));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= '0;
      end else if (!cra.module_enable || os_tick) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= BAUD_W'(div_cnt + 1'h1);
      end
   end

   // ------------------------------------------------------------
   // transmitter
   // ------------------------------------------------------------
   // clearing the enable freezes the frame where it stands
   assign tx_run = cra.module_enable & cra.transmitter_enable;
   assign tx_busy = tx_left != 4'h0;
   assign bit_end = tx_run & tx_busy & os_tick & (tx_os == os_last);
   assign tx_done = bit_end & (tx_left == 4'h1);
   // break waits for the current frame, before held data
   assign ld_idle = tx_run & !tx_busy & idle_pend;
   // a withdrawn request never reaches the shifter
   assign ld_brk = tx_run & !tx_busy & !idle_pend & break_send_request;
   // idle shifter takes the word at once
   // held word moves only once the shifter is free
   assign ld_data = tx_run & !tx_busy & !idle_pend & !break_send_request
                    & !tx_buffer_empty_flag;
   assign txw = cra.parity_enable ?
                add_par(tx_hold, nbits, cra.parity_odd) : tx_hold;
   assign txd = tx_shift[0];

   // enable edge queues one idle frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         te_q <= 1'h0;
         idle_pend <= 1'h0;
      end else begin
         te_q <= cra.transmitter_enable;
         if (ld_idle) begin
            idle_pend <= 1'h0;
         end
         if (cra.transmitter_enable && !te_q) begin
            idle_pend <= 1'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_shift <= `SCT_ONES12;
         tx_left <= 4'h0;
         tx_os <= 4'h0;
         tx_brk <= 1'h0;
      end else if (ld_idle || ld_brk || ld_data) begin
         tx_shift <= ld_idle ? `SCT_ONES12 :
                     frame(ld_brk ? 9'h0 : txw, nbits);
         tx_left <= flen;
         tx_os <= 4'h0;
         tx_brk <= ld_brk;
      end else if (tx_run && tx_busy && os_tick) begin
         if (tx_os == os_last) begin
            tx_os <= 4'h0;
            tx_shift <= {1'h1, tx_shift[11:1]};
            tx_left <= 4'(tx_left - 4'h1);
         end else begin
            tx_os <= 4'(tx_os + 4'h1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_hold <= 9'h0;
         tx_buffer_empty_flag <= 1'h1;
      end else begin
         if (wr_txd) begin
            tx_hold <= pwdata[8:0];
         end
         if (wr_txd) begin
            tx_buffer_empty_flag <= 1'h0;
         end else if (ld_data) begin
            tx_buffer_empty_flag <= 1'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_complete_flag <= 1'h0;
         break_send_request <= 1'h0;
      end else begin
         if (wr_txd || (wr_sts && !pwdata[`SCT_S_TXC])) begin
            tx_complete_flag <= 1'h0;
         end
         if (tx_done && tx_buffer_empty_flag) begin
            tx_complete_flag <= 1'h1;
         end
         if (tx_done && tx_brk) begin
            break_send_request <= 1'h0;
         end
         if (wr_req) begin
            break_send_request <= pwdata[0];
         end
      end
   end

   // ------------------------------------------------------------
   // receiver
   // ------------------------------------------------------------
   // decisions use the three samples before mid-bit
   assign rx_run = cra.module_enable & cra.receiver_enable;
   assign rx_mid = rx_run & os_tick & (rx_st != RX_IDLE)
                   & (rx_os == os_mid);
   assign bitv = maj3(smp);
   assign bit_nz = !(&smp) & (|smp);
   assign rx_done = rx_mid & (rx_st == RX_STOP);
   assign rx_algn = rx_sh >> (4'h9 - nbits);
   // a whole frame of ones after a character
   assign idle_hit = rx_run & os_tick & (rx_st == RX_IDLE) & rxd
                     & idle_arm & (rx_os == os_last)
                     & (idle_bits == 4'(flen - 4'h1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st <= RX_IDLE;
         rx_os <= 4'h0;
         rx_idx <= 4'h0;
         rx_sh <= 9'h0;
         smp <= 3'h7;
         nf_acc <= 1'h0;
         idle_arm <= 1'h0;
         idle_bits <= 4'h0;
      end else if (!rx_run) begin
         rx_st <= RX_IDLE;
         rx_os <= 4'h0;
         idle_arm <= 1'h0;
         idle_bits <= 4'h0;
      end else if (os_tick) begin
         smp <= {smp[1:0], rxd};
         if (rx_st != RX_IDLE) begin
            rx_os <= (rx_os == os_last) ? 4'h0 : 4'(rx_os + 4'h1);
         end
         case (rx_st)
            RX_IDLE: begin
               // start needs a falling edge: a break leaves the line low
               if (!rxd && smp[0]) begin
                  rx_st <= RX_START;
                  rx_os <= 4'h1;
                  nf_acc <= 1'h0;
                  idle_bits <= 4'h0;
               end else if (idle_arm && rxd) begin
                  if (rx_os == os_last) begin
                     rx_os <= 4'h0;
                     idle_bits <= 4'(idle_bits + 4'h1);
                  end else begin
                     rx_os <= 4'(rx_os + 4'h1);
                  end
                  if (idle_hit) begin
                     idle_arm <= 1'h0;
                  end
               end
            end
            RX_START: begin
               if (rx_os == os_mid) begin
                  nf_acc <= bit_nz;
                  rx_idx <= 4'h0;
                  rx_st <= bitv ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_os == os_mid) begin
                  nf_acc <= nf_acc | bit_nz;
                  rx_sh <= {bitv, rx_sh[8:1]};
                  rx_idx <= 4'(rx_idx + 4'h1);
                  if (rx_idx == 4'(nbits - 4'h1)) begin
                     rx_st <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (rx_os == os_mid) begin
                  rx_st <= RX_IDLE;
                  rx_os <= 4'h0;
                  idle_arm <= 1'h1;
                  idle_bits <= 4'h0;
               end
            end
            default: begin
               rx_st <= RX_IDLE;
            end
         endcase
      end
   end

   // multi-buffer mode follows the receive dma enable
   // read clears; zero write only in single-buffer mode
   assign rx_clr = rd_rxd | (wr_sts & !pwdata[`SCT_S_RXNE] & !dma_rx_en);
   // a character landing on the clearing cycle is still taken
   assign rxne_eff = rx_not_empty_flag & !rx_clr;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_data <= 9'h0;
         rx_not_empty_flag <= 1'h0;
         overrun_flag <= 1'h0;
         noise_flag <= 1'h0;
         framing_err_flag <= 1'h0;
         sts_seen <= 1'h0;
         idle_flag <= 1'h0;
      end else begin
         if (rd_sts) begin
            sts_seen <= 1'h1;
         end else if (rd_rxd) begin
            sts_seen <= 1'h0;
         end
         if (rd_rxd && sts_seen) begin
            overrun_flag <= 1'h0;
            noise_flag <= 1'h0;
            framing_err_flag <= 1'h0;
         end
         if (rx_clr) begin
            rx_not_empty_flag <= 1'h0;
         end
         if (rx_done && !rxne_eff) begin
            rx_not_empty_flag <= 1'h1;
            rx_data <= rx_algn;
            noise_flag <= nf_acc | bit_nz;
            // break ends in a low stop bit
            framing_err_flag <= !bitv;
         // old data stays, new is dropped
         end else if (rx_done) begin
            overrun_flag <= 1'h1;
         end
         if (wr_sts && !pwdata[`SCT_S_IDLE]) begin
            idle_flag <= 1'h0;
         end
         if (idle_hit) begin
            idle_flag <= 1'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // interrupt and dma requests
   // ------------------------------------------------------------
   assign tx_dma_req = tx_buffer_empty_flag & dma_tx_en;
   assign rx_dma_req = rx_not_empty_flag & dma_rx_en;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'h0;
      end else begin
         // noise and frame error interrupt only in multi-buffer mode
         irq <= (tx_buffer_empty_flag & cra.tx_empty_int_en)
              | (tx_complete_flag & cra.tx_complete_int_en)
              | (rx_not_empty_flag & cra.rx_not_empty_int_en)
              | (overrun_flag & (cra.rx_not_empty_int_en | error_int_en))
              | ((noise_flag | framing_err_flag) & error_int_en & dma_rx_en)
              | (idle_flag & cra.idle_int_en);
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_idle_first;
      ld_idle |=> tx_busy && (tx_shift == `SCT_ONES12) && !idle_pend;
   endproperty
   a_idle_first: assert property (p_idle_first) else $error("no idle");

   property p_start_low;
      ld_data |=> !txd && (tx_left == $past(flen));
   endproperty
   a_start_low: assert property (p_start_low) else $error("bad start");

   property p_txe_set;
      ld_data && !wr_txd |=> tx_buffer_empty_flag;
   endproperty
   a_txe_set: assert property (p_txe_set) else $error("txe not set");

   property p_wr_clr;
      wr_txd |=> !tx_buffer_empty_flag ##1 (tx_busy || !tx_run);
   endproperty
   a_wr_clr: assert property (p_wr_clr) else $error("txe not cleared");

   property p_hold;
      tx_busy && !tx_buffer_empty_flag && !tx_done |=> !tx_buffer_empty_flag;
   endproperty
   a_hold: assert property (p_hold) else $error("held word lost");

   property p_tc;
      tx_done && tx_buffer_empty_flag |=> tx_complete_flag;
   endproperty
   a_tc: assert property (p_tc) else $error("complete missing");

   property p_brk_clr;
      tx_done && tx_brk && !wr_req |=> !break_send_request;
   endproperty
   a_brk_clr: assert property (p_brk_clr) else $error("break stuck");

   property p_rxne;
      rx_done && !rxne_eff |=> rx_not_empty_flag
                                && (rx_data == $past(rx_algn));
   endproperty
   a_rxne: assert property (p_rxne) else $error("rx not stored");

   property p_ovr;
      rx_done && rxne_eff |=> overrun_flag && $stable(rx_data);
   endproperty
   a_ovr: assert property (p_ovr) else $error("overrun wrong");

   property p_fe;
      rx_done && !rxne_eff && !bitv |=> framing_err_flag;
   endproperty
   a_fe: assert property (p_fe) else $error("frame error missing");
endmodule
`default_nettype wire

// ---- verif/sct_line_peer.sv ----
// serial device model facing the core's line pins
`timescale 1ns/100ps
`default_nettype none
module sct_line_peer (
   input wire logic pclk,
   input wire logic [4:0] blen,
   input wire logic txd,
   output logic rxd,
   output logic [8:0] got,
   output logic got_stb
);
   logic [8:0] sh;
   // idle frame shows no edge, data lsb first
   initial begin
      rxd = 1'b1;
      got = 9'h000;
      got_stb = 1'b0;
      forever begin
         @(negedge txd);
         repeat (blen / 2) @(posedge pclk);
         for (int i = 0; i < 9; i++) begin
            repeat (blen) @(posedge pclk);
            sh[i] = txd;
         end
         got <= sh;
         got_stb <= 1'b1;
         @(posedge pclk);
         got_stb <= 1'b0;
      end
   end
   task automatic send(input logic [9:0] f);
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (blen) @(posedge pclk);
      end
      // one idle cycle keeps back-to-back frames apart
      rxd <= 1'b1;
      @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// ---- verif/sct_core_bench.sv ----
// self-checking bench for the serial character core
`timescale 1ns/100ps
`default_nettype none
`include "sct_defines.svh"
module sct_core_bench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, txd, rxd;
   logic want, got_stb;
   logic irq, tx_dma_req, rx_dma_req;
   logic [7:0] paddr, d;
   logic [8:0] got, d1;
   logic [4:0] blen;
   logic [31:0] pwdata, prdata;
   logic [35:0] exp_rd[$], msk_rd[$];
   logic [8:0] exp_tx[$];
   int failures, num_checks;
   sct_core sct_core_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
      .txd(txd), .irq(irq), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));
   sct_line_peer sct_line_peer_i (.pclk(pclk), .blen(blen), .txd(txd),
      .rxd(rxd), .got(got), .got_stb(got_stb));
   task automatic report_and_stop();
      failures += exp_tx.size();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic cmp(input logic [35:0] a, input logic [35:0] e);
      num_checks++;
      if (a !== e) begin
         failures++;
         $display("FAIL t=%0t act=%h exp=%h", $time, a, e);
      end
   endtask
   task automatic chk_rd(input logic [35:0] a);
      logic [35:0] m;
      m = msk_rd.pop_front();
      cmp(a & m, exp_rd.pop_front() & m);
   endtask
   task automatic chk_tx(input logic [8:0] a);
      cmp({27'h0, a}, {27'h0, exp_tx.pop_front()});
   endtask
   task automatic xfer(input logic w, input logic c, input logic [7:0] a,
         input logic [31:0] v, output logic [31:0] q);
      int n;
      want <= c;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] q;
      xfer(1'b1, 1'b0, a, v, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [35:0] e,
         input logic [35:0] m);
      logic [31:0] q;
      exp_rd.push_back(e);
      msk_rd.push_back(m);
      xfer(1'b0, 1'b1, a, 32'h0, q);
   endtask
   task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
      logic [31:0] q;
      int n;
      n = 0;
      do begin
         xfer(1'b0, 1'b0, a, 32'h0, q);
         n++;
      end while (q[b] !== v && n < 3000);
      if (n >= 3000) failures++;
   endtask
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && want) begin
         chk_rd({rx_dma_req, tx_dma_req, irq, pslverr, prdata});
      end
      if (got_stb) chk_tx(got);
   end
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      #400us;
      failures++;
      report_and_stop();
   end
   // enables stay up; only 8x sampling and multi-buffer mode vary
   initial begin
      void'($urandom(35089));
      {presetn, psel, penable, pwrite, want} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      blen = 5'h10;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk(`SCT_A_STS, 36'h1, 36'hf_0000_007f);
      rd_chk(`SCT_A_CRA, 36'h0, 36'hfff);
      rd_chk(8'h22, 36'h1_0000_0000, 36'hf_ffff_ffff);
      wr(`SCT_A_BRR, 32'h1);
      for (int os = 0; os < 2; os++) begin
         blen <= os ? 5'h08 : 5'h10;
         // complete interrupt enabled so irq follows the complete flag
         wr(`SCT_A_CRA, 32'h207 | (os << 3));
         for (int k = 0; k < 3; k++) begin
            d = 8'($urandom());
            wait_bit(`SCT_A_STS, 0, 1'b1);
            wr(`SCT_A_TXD, {24'h0, d});
            exp_tx.push_back({1'b1, d});
            rd_chk(`SCT_A_STS, 36'(k == 0 && os == 1),
               36'h2_0000_0003);
         end
         wait_bit(`SCT_A_STS, 1, 1'b1);
         rd_chk(`SCT_A_STS, 36'h2_0000_0003, 36'h2_0000_0003);
         wr(`SCT_A_REQ, 32'h1);
         exp_tx.push_back(9'h100);
         wait_bit(`SCT_A_REQ, 0, 1'b0);
         d1 = {1'b0, 8'($urandom())};
         sct_line_peer_i.send({1'b1, d1[7:0], 1'b0});
         wait_bit(`SCT_A_STS, 2, 1'b1);
         rd_chk(`SCT_A_RXD, {27'h0, d1}, 36'hff);
         rd_chk(`SCT_A_STS, 36'h0, 36'h3c);
         sct_line_peer_i.send({1'b1, d1[7:0], 1'b0});
         sct_line_peer_i.send({1'b1, ~d1[7:0], 1'b0});
         rd_chk(`SCT_A_STS, 36'hc, 36'hc);
         rd_chk(`SCT_A_RXD, {27'h0, d1}, 36'hff);
         rd_chk(`SCT_A_STS, 36'h0, 36'hc);
         sct_line_peer_i.send(10'h000);
         wait_bit(`SCT_A_STS, 2, 1'b1);
         // multi-buffer mode: a zero write must leave not-empty set
         wr(`SCT_A_CRC, 32'h2);
         wr(`SCT_A_STS, 32'h0);
         rd_chk(`SCT_A_STS, 36'h8_0000_0024, 36'he_0000_0024);
         rd_chk(`SCT_A_RXD, 36'h0, 36'hff);
         wr(`SCT_A_CRC, 32'h0);
         wait_bit(`SCT_A_STS, 6, 1'b1);
         rd_chk(`SCT_A_STS, 36'h40, 36'h40);
         wr(`SCT_A_STS, 32'hbf);
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
